/* File: verilog/mbcfg_regs.sv */
`timescale 1ns/1ps
module mbcfg_regs
  import mbcfg_pkg::*;
#(
  parameter int          N_IN          = 6,
  parameter int          CYC_PER_MS    = mbcfg_pkg::CYCLES_PER_MS,
  // Arbitrary identity value
  parameter logic [15:0] VERSION_TYPE  = 16'h0A01
)(
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset_n,
  // Register port from the protocol engine
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [15:0]            i_reg_wdata,
  output logic      [15:0]            o_reg_rdata,
  output logic                        o_reg_ack,
  output logic                        o_reg_err,
  // Packet events and link state
  input  wire logic                   i_pkt_rx_ok,
  input  wire logic                   i_pkt_rx_err,
  input  wire logic                   i_pkt_tx_done,
  input  wire logic                   i_link_busy,
  input  wire logic                   i_reply_req,
  output logic                        o_reply_go,
  // Switches, sensors, measurement
  input  wire logic [5:0]             i_dip_sw,
  input  wire logic [N_IN-1:0]        i_sensor_present,
  input  wire logic [15:0]            i_ch1_value,
  // Active link settings and low-pass time constant
  output logic      [19:0]            o_baud_bps,
  output mbcfg_pkg::mbcfg_parity_t    o_parity,
  output logic      [1:0]             o_stop_bits,
  output logic      [3:0]             o_data_bits,
  output logic                        o_ascii_mode,
  output logic      [7:0]             o_station_addr,
  output logic      [15:0]            o_lowpass_tc,
  // Indicators and outputs
  output logic                        o_restore_active,
  output logic                        o_led_comm,
  output logic      [N_IN-1:0]        o_led_inputs,
  output logic      [1:0]             o_alarm_out,
  output logic      [1:0]             o_led_outputs
);
  import mbcfg_pkg::*;

  localparam int LED_CYC = LED_HOLD_MS * CYC_PER_MS;

  // Stored registers
  logic [15:0]   baud_q;
  logic [7:0]    stop_q, data_q;
  logic [2:0]    parity_q;
  logic [15:0]   delay_q;
  logic          framing_q;
  logic [7:0]    station_q;
  logic [15:0]   lowpass_q;
  logic [15:0]   alarm_reg_q;
  logic [31:0]   cnt_q [3];
  logic          boot_q, restore_q;
  mbcfg_state_t  state_q;
  logic [31:0]   ms_cnt_q;
  logic [15:0]   ms_left_q;
  logic          answered_q;
  logic [31:0]   led_cnt_q;

  // Decode
  wire wr_baud    = i_reg_wr && (i_reg_addr == REG_BAUD);
  wire wr_charfmt = i_reg_wr && (i_reg_addr == REG_CHARFMT);
  wire wr_parity  = i_reg_wr && (i_reg_addr == REG_PARITY);
  wire wr_delay   = i_reg_wr && (i_reg_addr == REG_DELAY);
  wire wr_framing = i_reg_wr && (i_reg_addr == REG_FRAMING);
  wire wr_station = i_reg_wr && (i_reg_addr == REG_STATION);
  wire wr_lowpass = i_reg_wr && (i_reg_addr == REG_LOWPASS);
  wire wr_alarm   = i_reg_wr && (i_reg_addr == REG_ALARM_OUT);
  wire [7:0] wr_stop = i_reg_wdata[CHARFMT_STOP_LSB +: 8];
  wire [7:0] wr_data = i_reg_wdata[CHARFMT_DATA_LSB +: 8];
  // Illegal field values are dropped so the link never runs an undefined format
  wire stop_ok    = (wr_stop == 8'h01) || (wr_stop == 8'h02);
  wire data_ok    = (wr_data == 8'h07) || (wr_data == 8'h08);
  wire parity_ok  = (i_reg_wdata <= 16'h0004);
  wire framing_ok = (i_reg_wdata <= 16'h0001);
  wire restore    = boot_q && i_dip_sw[SW_RESTORE_BIT];
  wire ms_tick    = (ms_cnt_q == 32'(CYC_PER_MS - 1));

  // Power-up restore: switch sampled on the first clock after reset release
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      boot_q    <= 1'b1;
      restore_q <= 1'b0;
    end
    else
    begin
      boot_q <= 1'b0;
      if (restore)
        restore_q <= 1'b1;
    end
  end

  // Configuration registers; a restore overrides any write in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      baud_q    <= BAUD_RST;
      stop_q    <= STOP_RST;
      data_q    <= DATA_RST;
      parity_q  <= PARITY_RST;
      delay_q   <= DELAY_RST;
      framing_q <= FRAMING_RST;
      station_q <= STATION_RST;
      lowpass_q <= 16'h0000;
      alarm_reg_q <= 16'h0000;
    end
    else if (restore)
    begin
      baud_q    <= BAUD_RST;
      stop_q    <= STOP_RST;
      data_q    <= DATA_RST;
      parity_q  <= PARITY_RST;
      delay_q   <= DELAY_RST;
      framing_q <= FRAMING_RST;
      station_q <= STATION_RST;
      lowpass_q <= 16'h0000;
      alarm_reg_q <= 16'h0000;
    end
    else
    begin
      if (wr_baud)
        baud_q <= i_reg_wdata;
      if (wr_charfmt && stop_ok)
        stop_q <= wr_stop;
      if (wr_charfmt && data_ok)
        data_q <= wr_data;
      if (wr_parity && parity_ok)
        parity_q <= i_reg_wdata[2:0];
      if (wr_delay)
        delay_q <= i_reg_wdata;
      if (wr_framing && framing_ok)
        framing_q <= i_reg_wdata[0];
      if (wr_station)
        station_q <= i_reg_wdata[7:0];
      if (wr_lowpass)
        lowpass_q <= i_reg_wdata;
      if (wr_alarm)
        alarm_reg_q <= i_reg_wdata;
    end
  end

  // Packet counters: one generate entry per count
  wire [2:0] cnt_evt = {i_pkt_tx_done, i_pkt_rx_err, i_pkt_rx_ok};
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_cnt
      localparam logic [7:0] LO = REG_RX_LO + 8'(2 * g);
      wire wr_lo = i_reg_wr && (i_reg_addr == LO);
      wire wr_hi = i_reg_wr && (i_reg_addr == LO + 8'h01);
      // A software write wins over a count in the same cycle
      always_ff @(posedge i_clk_sys or negedge i_reset_n)
      begin
        if (!i_reset_n)
          cnt_q[g] <= 32'h0000_0000;
        else if (restore)
          cnt_q[g] <= 32'h0000_0000;
        else if (wr_lo)
          cnt_q[g][15:0] <= i_reg_wdata;
        else if (wr_hi)
          cnt_q[g][31:16] <= i_reg_wdata;
        else if (cnt_evt[g])
          cnt_q[g] <= cnt_q[g] + 32'h0000_0001;
      end
    end
  endgenerate

  // Baud decode from the stored code
  wire [19:0] baud_x10 = {4'h0, baud_q} * 20'h0000A;
  wire [19:0] baud_bps = (baud_q < 16'(BAUD_CODES)) ? BAUD_TABLE[baud_q[2:0]]
                                                    : baud_x10;
  wire [7:0]  sw_addr  = {3'h0, i_dip_sw[4:0]};
  wire [7:0]  station  = (station_q >= STATION_MIN) ? station_q : sw_addr;

  // Link settings move to the active set only while no frame is in flight
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_baud_bps     <= 20'h04B00;
      o_parity       <= MBCFG_PAR_NONE;
      o_stop_bits    <= 2'h1;
      o_data_bits    <= 4'h8;
      o_ascii_mode   <= 1'b0;
      o_station_addr <= 8'h00;
    end
    else if (!i_link_busy)
    begin
      o_baud_bps     <= baud_bps;
      o_parity       <= mbcfg_parity_t'(parity_q);
      o_stop_bits    <= stop_q[1:0];
      o_data_bits    <= data_q[3:0];
      o_ascii_mode   <= framing_q;
      o_station_addr <= station;
    end
  end

  // Millisecond divider, restarted with each reply request
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ms_cnt_q <= 32'h0000_0000;
    else if (i_reply_req || ms_tick)
      ms_cnt_q <= 32'h0000_0000;
    else
      ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
  end

  // Reply delay sequencer
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q   <= MBCFG_ST_IDLE;
      ms_left_q <= 16'h0000;
    end
    else
    begin
      unique case (state_q)
        MBCFG_ST_IDLE:
          if (i_reply_req)
          begin
            ms_left_q <= delay_q;
            state_q   <= (delay_q == 16'h0000) ? MBCFG_ST_GO : MBCFG_ST_WAIT;
          end
        MBCFG_ST_WAIT:
          if (ms_tick)
          begin
            ms_left_q <= ms_left_q - 16'h0001;
            if (ms_left_q == 16'h0001)
              state_q <= MBCFG_ST_GO;
          end
        MBCFG_ST_GO:
          state_q <= MBCFG_ST_IDLE;
      endcase
    end
  end

  // Communication light: a good packet followed by its answer being sent
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      answered_q <= 1'b0;
      led_cnt_q  <= 32'h0000_0000;
    end
    else
    begin
      if (i_pkt_rx_ok)
        answered_q <= 1'b1;
      else if (i_pkt_rx_err || i_pkt_tx_done)
        answered_q <= 1'b0;
      if (i_pkt_tx_done && answered_q)
        led_cnt_q <= 32'(LED_CYC);
      else if (led_cnt_q != 32'h0000_0000)
        led_cnt_q <= led_cnt_q - 32'h0000_0001;
    end
  end

  // Read mux; measurements arrive already scaled by the front end
  logic [15:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_mux = 16'h0000;
    rd_hit = 1'b1;
    unique case (i_reg_addr)
      REG_VERSION:   rd_mux = VERSION_TYPE;
      REG_SWITCHES:  rd_mux = {10'h000, i_dip_sw};
      REG_BAUD:      rd_mux = baud_q;
      REG_CHARFMT:   rd_mux = {stop_q, data_q};
      REG_PARITY:    rd_mux = {13'h0000, parity_q};
      REG_DELAY:     rd_mux = delay_q;
      REG_FRAMING:   rd_mux = {15'h0000, framing_q};
      REG_STATION:   rd_mux = {8'h00, station_q};
      REG_LOWPASS:   rd_mux = lowpass_q;
      REG_RX_LO:     rd_mux = cnt_q[0][15:0];
      REG_RX_HI:     rd_mux = cnt_q[0][31:16];
      REG_RXERR_LO:  rd_mux = cnt_q[1][15:0];
      REG_RXERR_HI:  rd_mux = cnt_q[1][31:16];
      REG_TX_LO:     rd_mux = cnt_q[2][15:0];
      REG_TX_HI:     rd_mux = cnt_q[2][31:16];
      REG_PRESENCE:  rd_mux = 16'(i_sensor_present);
      REG_ALARM_OUT: rd_mux = alarm_reg_q;
      REG_CH1_MEAS:  rd_mux = i_ch1_value;
      default:       rd_hit = 1'b0;
    endcase
  end

  wire wr_hit = wr_baud || wr_charfmt || wr_parity || wr_delay || wr_framing
             || wr_station || wr_lowpass || wr_alarm
             || (i_reg_wr && (i_reg_addr >= REG_RX_LO) && (i_reg_addr <= REG_TX_HI));

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack   <= 1'b0;
      o_reg_err   <= 1'b0;
    end
    else
    begin
      o_reg_ack   <= i_reg_rd || i_reg_wr;
      o_reg_err   <= (i_reg_rd && !rd_hit) || (i_reg_wr && !wr_hit);
      o_reg_rdata <= i_reg_rd ? rd_mux : 16'h0000;
    end
  end

  // Indicators and shared settings
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reply_go       <= 1'b0;
      o_led_comm       <= 1'b0;
      o_led_inputs     <= '0;
      o_alarm_out      <= 2'h0;
      o_led_outputs    <= 2'h0;
      o_lowpass_tc     <= 16'h0000;
      o_restore_active <= 1'b0;
    end
    else
    begin
      o_reply_go       <= (state_q == MBCFG_ST_GO);
      o_led_comm       <= (led_cnt_q != 32'h0000_0000);
      o_led_inputs     <= i_sensor_present;
      o_alarm_out      <= alarm_reg_q[ALARM_OUT_LSB +: 2];
      o_led_outputs    <= alarm_reg_q[ALARM_OUT_LSB +: 2];
      o_lowpass_tc     <= lowpass_q;
      o_restore_active <= restore_q;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  a_baud_code_map: assert property ((baud_q == 16'h0003) && !i_link_busy |=>
    o_baud_bps == 20'h04B00) else $error("baud code 3 not 19200");
  a_stop_legal: assert property (stop_q == 8'h01 || stop_q == 8'h02)
    else $error("illegal stop bits stored");
  a_data_legal: assert property (data_q == 8'h07 || data_q == 8'h08)
    else $error("illegal data bits stored");
  a_parity_legal: assert property (parity_q <= 3'h4)
    else $error("illegal parity stored");
  a_zero_delay_go: assert property ($rose(i_reply_req) && state_q == MBCFG_ST_IDLE
    && delay_q == 16'h0000 |-> ##2 o_reply_go) else $error("zero delay reply late");
  a_no_early_go: assert property (state_q == MBCFG_ST_WAIT && ms_left_q > 16'h0001
    |=> !o_reply_go) else $error("reply released early");
  a_restore_clear: assert property (restore |=> cnt_q[0] == 32'h0 && baud_q == BAUD_RST
    && alarm_reg_q == 16'h0) else $error("restore did not clear");
  a_link_hold: assert property (i_link_busy |=> $stable(o_baud_bps) && $stable(o_ascii_mode))
    else $error("link setting changed mid frame");
  a_cnt_step: assert property (i_pkt_rx_ok && !i_reg_wr && !restore
    |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1) else $error("rx counter did not step");
  a_alarm_out: assert property (##1 o_alarm_out == $past(alarm_reg_q[7:6]))
    else $error("alarm outputs do not follow register");
  a_led_cause: assert property ($rose(o_led_comm) |-> $past(i_pkt_tx_done, 2))
    else $error("comm light without answer");
  a_sw_addr: assert property (station_q < STATION_MIN && !i_link_busy |=>
    o_station_addr == {3'h0, $past(i_dip_sw[4:0])}) else $error("switch address wrong");

  c_restore: cover property (restore);
  c_delayed_reply: cover property (state_q == MBCFG_ST_WAIT ##[1:8] o_reply_go);
  c_comm_led: cover property ($rose(o_led_comm));
  c_cnt_carry: cover property (cnt_q[0][15:0] == 16'hFFFF && i_pkt_rx_ok);
endmodule

/* File: verilog/mbcfg_pkg.sv */
// Overview of operation
// - Baud codes 0..6 pick 2400..115200; any other code means rate/10.
// - Parity: 0 none, 1 odd, 2 even, 3 forced zero, 4 forced one.
// - Register 0x03 holds both stop-bit and data-bit counts.
// - Stop-bit field accepts one or two.
// - Data-bit field accepts seven or eight.
// - Each reply waits the millisecond count in register 0x05.
// - Register 0x06: zero selects RTU framing, one selects ASCII.
// - Station address from five switches weighted 1,2,4,8,16.
// - Restore switch on at power-up loads the default configuration.
// - A restore also clears every other register value.
// - Communication light only after a good packet was answered.
// - Input lights show connected sensors, output lights show outputs on.
// - One low-pass setting at 0x09 serves all inputs together.
// - Filter value is the time constant; larger is slower.
// - 32-bit received, error and sent counts as low/high pairs at 0x20.
// - Presence register 0x32 bits read high for connected sensors.
// - Output register 0x33 bits 6 and 7 drive the two alarm outputs.
// - Voltage given in 0.1 mV on 2048 mV range, 0.01 mV on 256 mV.
// - Read-only register 0x00 reports version and type.
// - Defaults: 19200 baud, no parity, 8 data, 1 stop, no delay, RTU.
// - Addresses 32..255 only through registers, never the switches.
// - Temperature in tenths of a degree, resistance in ohms.
package mbcfg_pkg;
  // Register indices
  localparam logic [7:0] REG_VERSION   = 8'h00;
  localparam logic [7:0] REG_SWITCHES  = 8'h01;
  localparam logic [7:0] REG_BAUD      = 8'h02;
  localparam logic [7:0] REG_CHARFMT   = 8'h03;
  localparam logic [7:0] REG_PARITY    = 8'h04;
  localparam logic [7:0] REG_DELAY     = 8'h05;
  localparam logic [7:0] REG_FRAMING   = 8'h06;
  localparam logic [7:0] REG_STATION   = 8'h07;
  localparam logic [7:0] REG_LOWPASS   = 8'h09;
  localparam logic [7:0] REG_RX_LO     = 8'h20;
  localparam logic [7:0] REG_RX_HI     = 8'h21;
  localparam logic [7:0] REG_RXERR_LO  = 8'h22;
  localparam logic [7:0] REG_RXERR_HI  = 8'h23;
  localparam logic [7:0] REG_TX_LO     = 8'h24;
  localparam logic [7:0] REG_TX_HI     = 8'h25;
  localparam logic [7:0] REG_PRESENCE  = 8'h32;
  localparam logic [7:0] REG_ALARM_OUT = 8'h33;
  localparam logic [7:0] REG_CH1_MEAS  = 8'h34;
  // Character format, alarm output and restore switch bit positions
  localparam int CHARFMT_STOP_LSB = 8;
  localparam int CHARFMT_DATA_LSB = 0;
  localparam int ALARM_OUT_LSB    = 6;
  localparam int SW_RESTORE_BIT   = 5;
  // Defaults after restore, and lowest station address taken from the register
  localparam logic [15:0] BAUD_RST    = 16'h0003;
  localparam logic [7:0]  STOP_RST    = 8'h01;
  localparam logic [7:0]  DATA_RST    = 8'h08;
  localparam logic [2:0]  PARITY_RST  = 3'h0;
  localparam logic [15:0] DELAY_RST   = 16'h0000;
  localparam logic        FRAMING_RST = 1'b0;
  localparam logic [7:0]  STATION_RST = 8'h00;
  localparam logic [7:0]  STATION_MIN = 8'h20;
  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int MS_IN_NS       = 1000000;
  localparam int CYCLES_PER_MS  = MS_IN_NS / CLK_PERIOD_NS;
  localparam int LED_HOLD_MS    = 50;
  // Baud table, codes 0..6
  localparam int BAUD_CODES = 7;
  localparam logic [19:0] BAUD_TABLE [BAUD_CODES] = '{
    20'h00960, 20'h012C0, 20'h02580, 20'h04B00, 20'h09600, 20'h0E100, 20'h1C200};
  typedef enum logic [2:0] {
    MBCFG_PAR_NONE = 3'h0, MBCFG_PAR_ODD = 3'h1, MBCFG_PAR_EVEN = 3'h2,
    MBCFG_PAR_ZERO = 3'h3, MBCFG_PAR_ONE = 3'h4} mbcfg_parity_t;
  typedef enum logic [2:0] {
    MBCFG_ST_IDLE = 3'b001, MBCFG_ST_WAIT = 3'b010, MBCFG_ST_GO = 3'b100} mbcfg_state_t;
endpackage

/* File: dv/mbcfg_master_model.sv */
`timescale 1ns/1ps
module mbcfg_master_model (
  // Clock
  input  wire logic        i_clk_sys,
  // Register port answer
  input  wire logic [15:0] i_reg_rdata,
  input  wire logic        i_reg_ack,
  input  wire logic        i_reg_err,
  // Register port request
  output logic      [7:0]  o_reg_addr,
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic      [15:0] o_reg_wdata,
  // Packet events and link state
  output logic             o_pkt_rx_ok,
  output logic             o_pkt_rx_err,
  output logic             o_pkt_tx_done,
  output logic             o_link_busy,
  output logic             o_reply_req
);
  initial
  begin
    {o_reg_wr, o_reg_rd, o_pkt_rx_ok, o_pkt_rx_err} = 4'h0;
    {o_pkt_tx_done, o_link_busy, o_reply_req} = 3'h0;
    o_reg_addr  = 8'hFF;
    o_reg_wdata = 16'hFFFF;
  end

  // One strobe cycle; the answer stands only in the following cycle
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic [1:0] r);
    @(negedge i_clk_sys);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = wr;
    o_reg_rd    = !wr;
    @(negedge i_clk_sys);
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    // Released lines flip, so a design that samples late sees garbage
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
    q           = i_reg_rdata;
    r           = {i_reg_ack, i_reg_err};
  endtask

  // Event pulse of one cycle: {reply request, good rx, bad rx, tx done}
  task automatic evt(input logic [3:0] m);
    @(negedge i_clk_sys);
    {o_reply_req, o_pkt_rx_ok, o_pkt_rx_err, o_pkt_tx_done} = m;
    @(negedge i_clk_sys);
    {o_reply_req, o_pkt_rx_ok, o_pkt_rx_err, o_pkt_tx_done} = 4'h0;
  endtask

  task automatic busy(input logic b);
    @(negedge i_clk_sys);
    o_link_busy = b;
  endtask
endmodule

/* File: dv/mbcfg_regs_bench.sv */
`timescale 1ns/1ps
module mbcfg_regs_bench;
  import mbcfg_pkg::*;
  localparam int CYC = 10;
  // Arbitrary identity value
  localparam logic [15:0] VT = 16'h5A3C;
  logic          i_clk_sys, i_reset_n, i_reg_wr, i_reg_rd, i_pkt_rx_ok, i_pkt_rx_err;
  logic          i_pkt_tx_done, i_link_busy, i_reply_req, o_reply_go, o_reg_ack, o_reg_err;
  logic          o_ascii_mode, o_restore_active, o_led_comm;
  logic [7:0]    i_reg_addr, o_station_addr;
  logic [15:0]   i_reg_wdata, o_reg_rdata, i_ch1_value, o_lowpass_tc, c;
  logic [5:0]    i_dip_sw, i_sensor_present, o_led_inputs;
  logic [19:0]   o_baud_bps;
  logic [1:0]    o_stop_bits, o_alarm_out, o_led_outputs;
  logic [3:0]    o_data_bits;
  mbcfg_parity_t o_parity;
  int            num_errors, n_checks, cyc, n;
  logic [15:0]   cf [3] = '{16'h0207, 16'h0309, 16'h0108};
  logic [5:0]    cf_exp [3] = '{6'h27, 6'h27, 6'h18};

  mbcfg_regs #(.CYC_PER_MS(CYC), .VERSION_TYPE(VT)) mbcfg_regs_i (.i_clk_sys, .i_reset_n,
    .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .o_reg_err,
    .i_pkt_rx_ok,
    .i_pkt_rx_err, .i_pkt_tx_done, .i_link_busy, .i_reply_req, .o_reply_go, .i_dip_sw,
    .i_sensor_present, .i_ch1_value, .o_baud_bps, .o_parity, .o_stop_bits, .o_data_bits,
    .o_ascii_mode, .o_station_addr, .o_lowpass_tc, .o_restore_active, .o_led_comm,
    .o_led_inputs, .o_alarm_out, .o_led_outputs);

  mbcfg_master_model master_i (.i_clk_sys(i_clk_sys), .i_reg_rdata(o_reg_rdata),
    .i_reg_ack(o_reg_ack), .i_reg_err(o_reg_err), .o_reg_addr(i_reg_addr),
    .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata),
    .o_pkt_rx_ok(i_pkt_rx_ok), .o_pkt_rx_err(i_pkt_rx_err), .o_pkt_tx_done(i_pkt_tx_done),
    .o_link_busy(i_link_busy), .o_reply_req(i_reply_req));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard: the sequence needs well under two thousand cycles
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    logic [15:0] q;
    logic [1:0]  r;
    master_i.access(1'b0, a, 16'h0000, q, r);
    chk(20'(r), 20'(er));
    if (er == 2'b10)
      chk(20'(q), 20'(e));
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic [15:0] q;
    logic [1:0]  r;
    master_i.access(1'b1, a, d, q, r);
    chk(20'(r), 20'(er));
    repeat (3) @(negedge i_clk_sys);
  endtask

  task automatic do_reset(input logic [5:0] sw);
    i_dip_sw  = sw;
    i_reset_n = 1'b0;
    repeat (6) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clk_sys);
  endtask

  initial
  begin
    {num_errors, n_checks, cyc} = '0;
    void'($urandom(27552));
    i_sensor_present = 6'h00;
    i_ch1_value      = 16'h0000;
    do_reset(6'h00);
    chk(o_baud_bps, 20'h04B00);
    chk({o_stop_bits, o_data_bits, o_parity, o_ascii_mode, o_restore_active}, 20'h00300);
    rd(REG_BAUD, 16'h0003, 2'b10);
    rd(REG_VERSION, VT, 2'b10);
    wr(REG_VERSION, 16'h1234, 2'b11);
    rd(8'h10, 16'h0000, 2'b11);
    master_i.evt(4'h1);
    repeat (3) @(negedge i_clk_sys);
    chk(o_led_comm, 1'b0);
    master_i.evt(4'h4);
    master_i.evt(4'h1);
    repeat (3) @(negedge i_clk_sys);
    chk(o_led_comm, 1'b1);
    $display("test defaults done");
    for (int i = 0; i < 9; i++)
    begin
      c = (i < 7) ? 16'(i) : 16'(7 + $urandom_range(9000));
      wr(REG_BAUD, c, 2'b10);
      chk(o_baud_bps, (i < 7) ? BAUD_TABLE[i] : 20'(c) * 20'h0000A);
    end
    for (int i = 0; i < 6; i++)
    begin
      wr(REG_PARITY, 16'(i), 2'b10);
      chk(20'(o_parity), (i < 5) ? 20'(i) : 20'h00004);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(REG_CHARFMT, cf[i], 2'b10);
      chk({o_stop_bits, o_data_bits}, 20'(cf_exp[i]));
      rd(REG_CHARFMT, {6'h00, cf_exp[i][5:4], 4'h0, cf_exp[i][3:0]}, 2'b10);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(REG_FRAMING, 16'(i + 1) % 16'h0003, 2'b10);
      chk(o_ascii_mode, (i < 2) ? 1'b1 : 1'b0);
    end
    $display("test link settings done");
    wr(REG_BAUD, 16'h0006, 2'b10);
    master_i.busy(1'b1);
    wr(REG_BAUD, 16'h0000, 2'b10);
    chk(o_baud_bps, BAUD_TABLE[6]);
    master_i.busy(1'b0);
    repeat (3) @(negedge i_clk_sys);
    chk(o_baud_bps, BAUD_TABLE[0]);
    for (int i = 0; i < 4; i++)
    begin
      i_dip_sw = (i == 0) ? 6'h1F : 6'($urandom_range(31));
      repeat (3) @(negedge i_clk_sys);
      chk(o_station_addr, 20'(i_dip_sw[4:0]));
      rd(REG_SWITCHES, 16'(i_dip_sw), 2'b10);
    end
    wr(REG_STATION, 16'h0020, 2'b10);
    chk(o_station_addr, 20'h00020);
    wr(REG_STATION, 16'h001F, 2'b10);
    chk(o_station_addr, 20'(i_dip_sw[4:0]));
    $display("test busy and address done");
    i_sensor_present = 6'($urandom);
    i_ch1_value      = 16'($urandom);
    c                = 16'($urandom);
    repeat (3) @(negedge i_clk_sys);
    chk(o_led_inputs, 20'(i_sensor_present));
    rd(REG_PRESENCE, 16'(i_sensor_present), 2'b10);
    rd(REG_CH1_MEAS, i_ch1_value, 2'b10);
    wr(REG_ALARM_OUT, 16'h0080, 2'b10);
    chk({o_alarm_out, o_led_outputs}, 20'h0000A);
    wr(REG_LOWPASS, c, 2'b10);
    chk(o_lowpass_tc, 20'(c));
    $display("test inputs and outputs done");
    // Counting must not depend on whether a frame is on the wire
    master_i.busy(1'($urandom_range(1)));
    for (int k = 0; k < 3; k++)
    begin
      wr(REG_RX_LO + 8'(2 * k), 16'hFFFE, 2'b10);
      wr(REG_RX_HI + 8'(2 * k), 16'hFFFF, 2'b10);
      n = 2 + $urandom_range(4);
      repeat (n) master_i.evt(4'h4 >> k);
      rd(REG_RX_LO + 8'(2 * k), 16'(n - 2), 2'b10);
      rd(REG_RX_HI + 8'(2 * k), 16'h0000, 2'b10);
    end
    master_i.busy(1'b0);
    for (int d = 0; d < 3; d += 2)
    begin
      wr(REG_DELAY, 16'(d), 2'b10);
      master_i.evt(4'h8);
      n = 0;
      while (o_reply_go !== 1'b1 && n < 200)
      begin
        @(negedge i_clk_sys);
        n++;
      end
      chk(20'(n >= d * CYC + 1 && n <= d * CYC + 3), 20'h00001);
    end
    $display("test counters and delay done");
    do_reset(6'h20);
    chk(o_restore_active, 1'b1);
    chk(o_baud_bps, 20'h04B00);
    rd(REG_LOWPASS, 16'h0000, 2'b10);
    rd(REG_TX_LO, 16'h0000, 2'b10);
    rd(REG_ALARM_OUT, 16'h0000, 2'b10);
    i_dip_sw = 6'h00;
    $display("test restore done");
    results();
  end
endmodule
